//--- rtl/adspc_pkg.sv
// Shared constants and types of the converter serial-port control block
package adspc_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_TIME_MIN_NS = 8500;
  localparam int CONV_TIME_MAX_NS = 10000;
  localparam int START_ALIGN_NS = 30;
  localparam int CONV_RISES_SHORT = 19;
  localparam int CONV_RISES_LONG = 20;
  localparam int WORD_BITS = 16;
  localparam int LEAD_ZEROS = 4;
  localparam int CODE_BITS = 12;

  // Oscillator period in system cycles, longest that still fits the window
  localparam int OSC_CYC =
    CONV_TIME_MAX_NS / (CONV_RISES_SHORT * CLK_PERIOD_NS);
  localparam int OSC_HI_CYC = OSC_CYC / 2;
  localparam int OSC_LO_CYC = OSC_CYC - OSC_HI_CYC;
  // Alignment window rounded down, but never below one cycle
  localparam int START_ALIGN_CYC =
    (START_ALIGN_NS / CLK_PERIOD_NS) < 1 ? 1 : START_ALIGN_NS / CLK_PERIOD_NS;

  localparam logic [4:0] WORD_LAST_BIT = 5'(WORD_BITS - 1);
  localparam logic [4:0] WORD_COUNT = 5'(WORD_BITS);
  localparam logic [4:0] RISES_SHORT = 5'(CONV_RISES_SHORT);
  localparam logic [4:0] RISES_LONG = 5'(CONV_RISES_LONG);
  localparam logic [LEAD_ZEROS-1:0] LEAD_PATTERN = 4'h0;
  localparam logic [CODE_BITS-1:0] CODE_RESET = 12'h000;

  typedef struct packed {
    logic out;
    logic oe_n;
  } adspc_od_type;

  localparam adspc_od_type OD_RELEASED = '{out: 1'b0, oe_n: 1'b1};

  typedef enum logic [0:0] {ST_IDLE, ST_CONV} adspc_state_type;

  // Open-drain: a low level is driven, a high level is left to the pull-up
  function automatic adspc_od_type adspc_od(input logic level);
    adspc_od = '{out: 1'b0, oe_n: level};
  endfunction : adspc_od

endpackage : adspc_pkg

//--- rtl/adspc_tx_deser.sv
// Transmit-side deserialiser running on the host's transmit clock
module adspc_tx_deser
  import adspc_pkg::*;
(
  // Link clock and reset
  input wire logic tx_clk_i,
  input wire logic rst_i,
  // Serial transmit pins
  input wire logic tx_frame_n_i,
  input wire logic tx_serial_in_i,
  // Input latch and word-done toggle
  output logic [CODE_BITS-1:0] in_latch_o,
  output logic word_tgl_o
);

  logic [WORD_BITS-2:0] shift_ff;
  logic [4:0] cnt_ff;
  logic [CODE_BITS-1:0] latch_ff;
  logic tgl_ff;

  wire logic take_bit = !tx_frame_n_i && (cnt_ff < WORD_COUNT);
  wire logic last_bit = take_bit && (cnt_ff == WORD_LAST_BIT);
  wire logic [WORD_BITS-1:0] full_word = {shift_ff, tx_serial_in_i};

  // Data is valid at the falling transmit clock edge
  always_ff @(negedge tx_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_ff <= '0;
      cnt_ff <= 5'h00;
      latch_ff <= CODE_RESET;
      tgl_ff <= 1'b0;
    end else begin
      if (tx_frame_n_i) begin
        cnt_ff <= 5'h00;
      end else if (take_bit) begin
        shift_ff <= full_word[WORD_BITS-2:0];
        cnt_ff <= cnt_ff + 5'h01;
      end
      if (last_bit) begin
        latch_ff <= full_word[CODE_BITS-1:0];
        tgl_ff <= !tgl_ff;
      end
    end
  end

  assign in_latch_o = latch_ff;
  assign word_tgl_o = tgl_ff;

endmodule : adspc_tx_deser

//--- rtl/adspc_top.sv
// Converter serial-port control: sampling side, receive port, playback latches
module adspc_top
  import adspc_pkg::*;
#(
  parameter int OSC_HI = OSC_HI_CYC,
  parameter int OSC_LO = OSC_LO_CYC
) (
  // System clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Sample clock source and mode straps
  input wire logic SAMPLE_CLK_I,
  input wire logic SAMPLE_CLK_TIED_VSS_I,
  input wire logic RX_CLOCK_CONTINUOUS_I,
  // Conversion control and sampled code
  input wire logic CONVERSION_START_I,
  input wire logic [CODE_BITS-1:0] ADC_CODE_I,
  // Receive serial port, open-drain
  output adspc_od_type RX_FRAME_N_O,
  output adspc_od_type RX_SERIAL_OUT_O,
  output adspc_od_type RX_SERIAL_CLOCK_O,
  // Sampler and conversion status
  output logic TRACK_HOLD_O,
  output logic CONV_BUSY_O,
  // Transmit serial port
  input wire logic TX_SERIAL_CLOCK_I,
  input wire logic TX_FRAME_N_I,
  input wire logic TX_SERIAL_IN_I,
  // Output latch
  input wire logic OUTPUT_LOAD_STROBE_N_I,
  output logic [CODE_BITS-1:0] DAC_CODE_O
);

  import adspc_pkg::*;

  if (OSC_HI < 1 || OSC_LO < 1 || OSC_HI + OSC_LO > 7) begin : g_chk
    $error("adspc_top: oscillator phases must be 1..7 cycles in total");
  end

  // Two-stage synchronisers for the sample clock, both straps, start, load strobe and word toggle
  logic ext_clk_s1_ff, ext_clk_s2_ff;
  logic strap_s1_ff, strap_s2_ff;
  logic cont_s1_ff, cont_s2_ff;
  logic start_s1_ff, start_s2_ff, start_q_ff;
  logic load_s1_ff, load_s2_ff, load_q_ff;
  logic tgl_s1_ff, tgl_s2_ff, tgl_q_ff;

  // Playback side signals from the transmit clock domain
  logic [CODE_BITS-1:0] tx_in_latch;
  logic tx_word_tgl;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ext_clk_s1_ff <= 1'b0;
      ext_clk_s2_ff <= 1'b0;
      strap_s1_ff <= 1'b0;
      strap_s2_ff <= 1'b0;
      cont_s1_ff <= 1'b0;
      cont_s2_ff <= 1'b0;
      start_s1_ff <= 1'b0;
      start_s2_ff <= 1'b0;
      start_q_ff <= 1'b0;
      load_s1_ff <= 1'b1;
      load_s2_ff <= 1'b1;
      load_q_ff <= 1'b1;
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      tgl_q_ff <= 1'b0;
    end else begin
      ext_clk_s1_ff <= SAMPLE_CLK_I;
      ext_clk_s2_ff <= ext_clk_s1_ff;
      strap_s1_ff <= SAMPLE_CLK_TIED_VSS_I;
      strap_s2_ff <= strap_s1_ff;
      cont_s1_ff <= RX_CLOCK_CONTINUOUS_I;
      cont_s2_ff <= cont_s1_ff;
      start_s1_ff <= CONVERSION_START_I;
      start_s2_ff <= start_s1_ff;
      start_q_ff <= start_s2_ff;
      load_s1_ff <= OUTPUT_LOAD_STROBE_N_I;
      load_s2_ff <= load_s1_ff;
      load_q_ff <= load_s2_ff;
      tgl_s1_ff <= tx_word_tgl;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_q_ff <= tgl_s2_ff;
    end
  end

  // Mode decode
  wire logic use_int = strap_s2_ff;
  wire logic cont_mode = cont_s2_ff;
  wire logic gated_int = use_int && !cont_mode;
  wire logic start_rise = start_s2_ff && !start_q_ff;
  wire logic load_fall = !load_s2_ff && load_q_ff;
  wire logic word_seen = tgl_s2_ff ^ tgl_q_ff;

  // Internal oscillator; in gated mode it waits idle and restarts on a start
  adspc_state_type state_ff;
  logic [2:0] osc_cnt_ff;
  logic osc_lvl_ff;

  wire logic osc_hold = gated_int && (state_ff == ST_IDLE) && !start_rise;
  wire logic [2:0] osc_phase = osc_lvl_ff ? 3'(OSC_HI) : 3'(OSC_LO);
  wire logic osc_wrap = (osc_cnt_ff == osc_phase - 3'h1);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      osc_cnt_ff <= 3'h0;
      osc_lvl_ff <= 1'b0;
    end else if (osc_hold) begin
      osc_cnt_ff <= 3'h0;
      osc_lvl_ff <= 1'b0;
    end else if (osc_wrap) begin
      osc_cnt_ff <= 3'h0;
      osc_lvl_ff <= !osc_lvl_ff;
    end else begin
      osc_cnt_ff <= osc_cnt_ff + 3'h1;
    end
  end

  // Active sample clock and its edges
  logic sclk_q_ff;
  wire logic sclk = use_int ? osc_lvl_ff : ext_clk_s2_ff;
  wire logic sclk_rise = sclk && !sclk_q_ff;
  wire logic sclk_fall = !sclk && sclk_q_ff;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sclk_q_ff <= 1'b0;
    end else begin
      sclk_q_ff <= sclk;
    end
  end

  // Conversion sequencer
  logic [WORD_BITS-1:0] shift_ff;
  logic [4:0] bit_cnt_ff;
  logic [4:0] rise_cnt_ff;
  logic [4:0] rise_goal_ff;
  logic hold_ff;
  logic framing_ff;
  // A bit may only advance once the host has seen a fall for the last one
  logic fall_seen_ff;

  // A sample edge landing with the start means the start was just before it
  wire logic aligned = sclk_rise && !gated_int;
  wire logic [4:0] goal =
    aligned ? RISES_LONG : RISES_SHORT;
  wire logic conv_rise = (state_ff == ST_CONV) && sclk_rise;
  wire logic bit_step = conv_rise && fall_seen_ff;
  wire logic conv_done = conv_rise && (rise_cnt_ff + 5'h01 == rise_goal_ff);
  wire logic more_bits = bit_cnt_ff < WORD_LAST_BIT;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_ff <= ST_IDLE;
      shift_ff <= '0;
      bit_cnt_ff <= 5'h00;
      rise_cnt_ff <= 5'h00;
      rise_goal_ff <= RISES_SHORT;
      hold_ff <= 1'b0;
      framing_ff <= 1'b0;
      fall_seen_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start_rise) begin
            state_ff <= ST_CONV;
            hold_ff <= 1'b1;
            framing_ff <= 1'b1;
            shift_ff <= {LEAD_PATTERN, ADC_CODE_I};
            bit_cnt_ff <= 5'h00;
            rise_cnt_ff <= 5'h00;
            rise_goal_ff <= goal;
            fall_seen_ff <= 1'b0;
          end
        end
        ST_CONV: begin
          if (sclk_fall) begin
            fall_seen_ff <= 1'b1;
          end
          if (conv_rise) begin
            rise_cnt_ff <= rise_cnt_ff + 5'h01;
          end
          if (bit_step) begin
            if (more_bits) begin
              shift_ff <= {shift_ff[WORD_BITS-2:0], 1'b1};
              bit_cnt_ff <= bit_cnt_ff + 5'h01;
            end else begin
              framing_ff <= 1'b0;
            end
          end
          if (conv_done) begin
            state_ff <= ST_IDLE;
            hold_ff <= 1'b0;
            framing_ff <= 1'b0;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin drive, registered from the sequencer's next state on the same edge
  wire logic nxt_framing = (state_ff == ST_IDLE) ? start_rise :
    (framing_ff && !(bit_step && !more_bits) && !conv_done);
  wire logic nxt_bit = (state_ff == ST_IDLE) ? LEAD_PATTERN[LEAD_ZEROS-1] :
    (bit_step && more_bits) ? shift_ff[WORD_BITS-2] : shift_ff[WORD_BITS-1];
  wire logic nxt_clk_on = cont_mode || (state_ff == ST_CONV) || start_rise;

  adspc_od_type frame_ff, data_ff, rclk_ff;
  logic busy_ff;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      frame_ff <= OD_RELEASED;
      data_ff <= OD_RELEASED;
      rclk_ff <= OD_RELEASED;
      busy_ff <= 1'b0;
    end else begin
      frame_ff <= adspc_od(!nxt_framing);
      data_ff <= nxt_framing ? adspc_od(nxt_bit) : OD_RELEASED;
      if (nxt_clk_on) begin
        rclk_ff <= adspc_od(sclk);
      end else begin
        rclk_ff <= OD_RELEASED;
      end
      busy_ff <= (state_ff == ST_CONV) && !conv_done || start_rise;
    end
  end

  // Playback side: deserialiser on the transmit clock, latches here
  adspc_tx_deser adspc_tx_deser_i (
    .tx_clk_i(TX_SERIAL_CLOCK_I),
    .rst_i(RST_I),
    .tx_frame_n_i(TX_FRAME_N_I),
    .tx_serial_in_i(TX_SERIAL_IN_I),
    .in_latch_o(tx_in_latch),
    .word_tgl_o(tx_word_tgl)
  );

  // The deserialiser holds its latch for a whole word after each toggle
  logic [CODE_BITS-1:0] in_copy_ff;
  logic [CODE_BITS-1:0] out_latch_ff;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      in_copy_ff <= CODE_RESET;
      out_latch_ff <= CODE_RESET;
    end else begin
      if (word_seen) begin
        in_copy_ff <= tx_in_latch;
      end
      if (load_fall) begin
        out_latch_ff <= word_seen ? tx_in_latch : in_copy_ff;
      end
    end
  end

  assign RX_FRAME_N_O = frame_ff;
  assign RX_SERIAL_OUT_O = data_ff;
  assign RX_SERIAL_CLOCK_O = rclk_ff;
  assign TRACK_HOLD_O = hold_ff;
  assign CONV_BUSY_O = busy_ff;
  assign DAC_CODE_O = out_latch_ff;

endmodule : adspc_top

//--- verif/adspc_chk.sv
// Port-level assertions of the converter serial-port control block
module adspc_chk
  import adspc_pkg::*;
(
  // Clock, reset and inputs
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SAMPLE_CLK_TIED_VSS_I,
  input wire logic RX_CLOCK_CONTINUOUS_I,
  input wire logic CONVERSION_START_I,
  // Observed outputs
  input wire adspc_od_type RX_FRAME_N_O,
  input wire adspc_od_type RX_SERIAL_OUT_O,
  input wire adspc_od_type RX_SERIAL_CLOCK_O,
  input wire logic TRACK_HOLD_O,
  input wire logic CONV_BUSY_O
);
  logic [4:0] rises_ff;
  logic clk_d_ff;
  logic busy_d_ff;
  wire rclk = RX_SERIAL_CLOCK_O.oe_n | RX_SERIAL_CLOCK_O.out;
  wire busy_any = CONV_BUSY_O | busy_d_ff;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // Receive clock rises seen across one conversion
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rises_ff <= 5'h00;
      clk_d_ff <= 1'b1;
      busy_d_ff <= 1'b0;
    end else begin
      clk_d_ff <= rclk;
      busy_d_ff <= CONV_BUSY_O;
      if (!busy_any) begin
        rises_ff <= 5'h00;
      end else if (busy_d_ff && rclk && !clk_d_ff) begin
        rises_ff <= rises_ff + 5'h01;
      end
    end
  end
  a_hold_busy: assert property (TRACK_HOLD_O == CONV_BUSY_O)
    else $error("hold differs from busy");
  a_start_sync: assert property (
    $rose(CONVERSION_START_I) && !CONV_BUSY_O |-> ##[2:5] CONV_BUSY_O)
    else $error("start not taken");
  a_frame_start: assert property ($rose(CONV_BUSY_O) |->
    !RX_FRAME_N_O.oe_n && !RX_SERIAL_OUT_O.oe_n)
    else $error("frame or first bit missing");
  a_frame_idle: assert property (!CONV_BUSY_O |-> RX_FRAME_N_O.oe_n)
    else $error("frame low while idle");
  a_od_low: assert property (!(RX_FRAME_N_O.out |
    RX_SERIAL_OUT_O.out | RX_SERIAL_CLOCK_O.out))
    else $error("open-drain drives high");
  a_data_framed: assert property (
    RX_FRAME_N_O.oe_n |-> RX_SERIAL_OUT_O.oe_n)
    else $error("data driven outside frame");
  a_lead_zeros: assert property ($fell(RX_FRAME_N_O.oe_n) |->
    !RX_SERIAL_OUT_O.oe_n [*8])
    else $error("leading bits not zero");
  a_rise_count: assert property (
    $fell(busy_d_ff) |-> rises_ff inside {5'h13, 5'h14})
    else $error("conversion length wrong");
  a_gated_int: assert property ($fell(busy_d_ff) &&
    SAMPLE_CLK_TIED_VSS_I && !RX_CLOCK_CONTINUOUS_I |-> rises_ff == 5'h13)
    else $error("gated internal length wrong");
endmodule : adspc_chk

bind adspc_top adspc_chk adspc_chk_i (.CLK_I(CLK_I), .RST_I(RST_I),
  .SAMPLE_CLK_TIED_VSS_I(SAMPLE_CLK_TIED_VSS_I),
  .RX_CLOCK_CONTINUOUS_I(RX_CLOCK_CONTINUOUS_I),
  .CONVERSION_START_I(CONVERSION_START_I), .RX_FRAME_N_O(RX_FRAME_N_O),
  .RX_SERIAL_OUT_O(RX_SERIAL_OUT_O), .RX_SERIAL_CLOCK_O(RX_SERIAL_CLOCK_O),
  .TRACK_HOLD_O(TRACK_HOLD_O), .CONV_BUSY_O(CONV_BUSY_O));

//--- verif/adspc_host.sv
// Behavioural host serial port: sends playback words, collects results
module adspc_host (
  // Receive wires
  input wire logic rx_frame_n_i,
  input wire logic rx_serial_out_i,
  input wire logic rx_clock_i,
  // Transmit pins
  output logic tx_serial_clock_o,
  output logic tx_frame_n_o,
  output logic tx_serial_in_o,
  // Last received word
  output logic [15:0] rx_word_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tx_serial_clock_o = 1'b1;
    tx_frame_n_o = 1'b1;
    tx_serial_in_o = 1'b0;
    rx_word_o = 16'h0000;
    // One falling edge while reset is held
    #50 tx_serial_clock_o = 1'b0;
    #3 tx_serial_clock_o = 1'b1;
  end
  always @(negedge rx_clock_i) begin
    if (!rx_frame_n_i) begin
      rx_word_o = {rx_word_o[14:0], rx_serial_out_i};
    end
  end
  // Clock stands high outside the frame; one extra fall shows frame high
  task automatic send(input logic [15:0] w);
    int i;
    tx_frame_n_o = 1'b0;
    for (i = 15; i >= 0; i--) begin
      tx_serial_in_o = w[i];
      #3 tx_serial_clock_o = 1'b0;
      #3 tx_serial_clock_o = 1'b1;
    end
    tx_frame_n_o = 1'b1;
    tx_serial_in_o = ~w[0];
    #3 tx_serial_clock_o = 1'b0;
    #3 tx_serial_clock_o = 1'b1;
  endtask : send
endmodule : adspc_host

//--- verif/test_adc_dac_serial_port_control.sv
// Self-checking bench of the converter serial-port control block
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin \
  n_errors++; $display("CHECK FAILED %0t %s", $time, msg); end end
module test_adc_dac_serial_port_control;
  import adspc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, sclk, strap, cont, start, strobe_n, hold, busy;
  logic tx_clk, tx_frame_n, tx_data;
  logic [11:0] code, dac;
  logic [15:0] rx_word;
  adspc_od_type frame_o, data_o, rck_o;
  int n_errors = 0;
  int cmp_count = 0;
  wire frame_w = frame_o.oe_n | frame_o.out;
  wire data_w = data_o.oe_n | data_o.out;
  wire rck_w = rck_o.oe_n | rck_o.out;
  adspc_top adspc_top_i (.CLK_I(clk), .RST_I(rst), .SAMPLE_CLK_I(sclk),
    .SAMPLE_CLK_TIED_VSS_I(strap), .RX_CLOCK_CONTINUOUS_I(cont),
    .CONVERSION_START_I(start), .ADC_CODE_I(code), .RX_FRAME_N_O(frame_o),
    .RX_SERIAL_OUT_O(data_o), .RX_SERIAL_CLOCK_O(rck_o),
    .TRACK_HOLD_O(hold), .CONV_BUSY_O(busy), .TX_SERIAL_CLOCK_I(tx_clk),
    .TX_FRAME_N_I(tx_frame_n), .TX_SERIAL_IN_I(tx_data),
    .OUTPUT_LOAD_STROBE_N_I(strobe_n), .DAC_CODE_O(dac));
  adspc_host adspc_host_i (.rx_frame_n_i(frame_w), .rx_serial_out_i(data_w),
    .rx_clock_i(rck_w), .tx_serial_clock_o(tx_clk),
    .tx_frame_n_o(tx_frame_n), .tx_serial_in_o(tx_data),
    .rx_word_o(rx_word));
  task conclude;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  // One conversion in the given clock mode, a refused start inside it
  task t_convert(input logic int_osc, input logic run, input logic [11:0] c);
    int i;
    logic l;
    @(posedge clk);
    strap <= int_osc;
    cont <= run;
    code <= c;
    repeat (20) @(posedge clk);
    start <= 1'b1;
    for (i = 0; i < 10 && busy !== 1'b1; i++) @(posedge clk);
    `CHK(hold, 1'b1, "no hold at start");
    `CHK(frame_w, 1'b0, "frame not low");
    start <= 1'b0;
    repeat (30) @(posedge clk);
    start <= 1'b1;
    for (i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk);
    `CHK(rx_word, {4'h0, c}, "result word");
    `CHK(frame_w, 1'b1, "frame not released");
    repeat (25) @(posedge clk);
    `CHK(busy, 1'b0, "refused start converted");
    start <= 1'b0;
    l = rck_w;
    for (i = 0; i < 10 && rck_w === l; i++) @(posedge clk);
    if (run) `CHK(rck_w, ~l, "clock stopped");
    if (!run) `CHK(rck_w, 1'b1, "clock not released");
  endtask : t_convert
  // Two words, load strobe after the second only
  task t_load(input logic [15:0] w1, input logic [15:0] w2,
              input logic [11:0] old);
    adspc_host_i.send(w1);
    adspc_host_i.send(w2);
    repeat (6) @(posedge clk);
    `CHK(dac, old, "loaded without strobe");
    strobe_n <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(dac, w2[11:0], "output code");
    strobe_n <= 1'b1;
  endtask : t_load
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    sclk = 1'b0;
    forever #250 sclk = ~sclk;
  end
  initial begin
    #1000000;
    n_errors++;
    conclude;
  end
  initial begin
    {rst, strap, cont, start, strobe_n, code} = {4'h8, 1'b1, 12'h000};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(dac, 12'h000, "output reset");
    t_convert(1'b0, 1'b1, 12'h5a3);
    t_convert(1'b0, 1'b0, 12'h800);
    t_convert(1'b1, 1'b1, 12'h7ff);
    t_convert(1'b1, 1'b0, 12'h001);
    t_load(16'hf123, 16'h0abc, 12'h000);
    t_load(16'h5fff, 16'ha800, 12'habc);
    conclude;
  end
endmodule : test_adc_dac_serial_port_control
